// ===== cce_pkg.sv
// constants and carrier types shared by the calibration command executor
// assumes a single 250 MHz clock domain and an APB register slave
package cce_pkg;
    // apb register byte offsets
    localparam logic [7:0] REG_NIBBLE   = 8'h00;
    localparam logic [7:0] REG_STATUS   = 8'h04;
    localparam logic [7:0] REG_HOLDING  = 8'h08;
    localparam logic [7:0] REG_READBACK = 8'h0C;
    localparam logic [7:0] REG_BAUD     = 8'h10;
    localparam logic [7:0] REG_ADDRESS  = 8'h14;
    // reset values
    localparam logic [7:0] BAUD_RESET   = 8'h04;
    // nonvolatile store geometry
    localparam logic [9:0] STORE_BYTES  = 10'h300;
    localparam logic [9:0] STORE_LAST   = 10'h2FF;
    localparam logic [3:0] PAGE_COUNT   = 4'hC;
    localparam logic [5:0] PAGE_LAST    = 6'h3F;
    localparam logic [7:0] ERASED_BYTE  = 8'hFF;
    localparam logic [3:0] CAL_COUNT    = 4'h5;
    // command codes
    localparam logic [3:0] LOAD_CAL_COMMAND       = 4'h0;
    localparam logic [3:0] STORE_WRITE_COMMAND    = 4'h1;
    localparam logic [3:0] STORE_ERASE_COMMAND    = 4'h2;
    localparam logic [3:0] READ_CAL_COMMAND       = 4'h3;
    localparam logic [3:0] STORE_READ_COMMAND     = 4'h4;
    localparam logic [3:0] INTERFACE_READ_COMMAND = 4'h5;
    localparam logic [3:0] ANALOG_PROBE_COMMAND   = 4'h6;
    localparam logic [3:0] BLOCK_WIPE_COMMAND     = 4'h7;
    // interface nibble addresses
    localparam logic [3:0] NA_STORE_LO  = 4'h6;
    localparam logic [3:0] NA_STORE_MID = 4'h7;
    localparam logic [3:0] NA_POINTER   = 4'h8;
    localparam logic [3:0] NA_COMMAND   = 4'h9;
    localparam logic [3:0] NA_HOLD_LEN  = 4'hA;
    localparam logic [3:0] NA_SOURCE    = 4'hB;
    // readback pointer codes
    localparam logic [3:0] PTR_HOLD_LO  = 4'h0;
    localparam logic [3:0] PTR_HOLD_HI  = 4'h1;
    localparam logic [3:0] PTR_ADDR_SEL = 4'h2;
    localparam logic [3:0] PTR_CMD_PTR  = 4'h3;
    localparam logic [3:0] PTR_ANALOG   = 4'h4;
    localparam logic [3:0] PTR_ADDR_LO  = 4'h5;
    localparam logic [3:0] PTR_DATA     = 4'h6;
    localparam logic [3:0] PTR_TEMP     = 4'h7;
    localparam logic [3:0] PTR_BAUD     = 4'h8;
    localparam logic [3:0] PTR_TEST     = 4'h9;
    localparam logic [7:0] CHECK_PATTERN = 8'hCA;
    // analog hold spans, in byte times
    localparam logic [3:0]  HOLD_FOREVER = 4'hF;
    localparam logic [15:0] LONG_SPAN    = 16'h8001;
    localparam logic [3:0]  BITS_PER_BYTE = 4'h8;

    typedef enum logic [2:0]
    {
        CCE_IDLE  = 3'b001,
        CCE_WIPE  = 3'b010,
        CCE_PROBE = 3'b100
    } cce_state_t;

    typedef logic [4:0][15:0] cce_cal_regs_t;

    typedef struct packed {
        logic       valid;
        logic [7:0] data;
    } cce_readback_t;

    typedef struct packed {
        logic       drive;
        logic [3:0] source;
    } cce_probe_t;

    typedef struct packed {
        logic [7:0] cyc;
        logic [3:0] bits;
        logic       tick;
    } cce_timer_t;

    typedef struct packed {
        cce_state_t    st;
        logic [15:0]   holding_word;
        logic [3:0]    cal_register_select;
        logic [3:0]    addr_mid;
        logic [3:0]    readback_pointer;
        logic [3:0]    command_nibble;
        logic [3:0]    analog_hold_length;
        cce_probe_t    probe;
        logic [9:0]    wipe_addr;
        logic [9:0]    wipe_end;
        logic [15:0]   span_left;
        cce_readback_t rb;
        logic [7:0]    baud_period_count;
        cce_cal_regs_t cal;
    } cce_exec_t;
endpackage : cce_pkg

// ===== cce_byte_timer.sv
// byte-time enable generator for the command executor
// assumes bit_cycles holds clock cycles per serial bit period
`timescale 1ns/10ps
`default_nettype none
module cce_byte_timer
(
    input  wire logic       pclk,
    input  wire logic       presetn,
    input  wire logic       run,
    input  wire logic [7:0] bit_cycles,
    output logic            byte_tick
);
    cce_pkg::cce_timer_t q;      // registered state
    cce_pkg::cce_timer_t next_q; // next state

    // count bit periods, pulse once every eight of them
    always_comb
    begin
        next_q = q;
        next_q.tick = 1'b0;
        if (!run)
        begin
            // restart so each span begins on a fresh byte
            next_q.cyc  = 8'h00;
            next_q.bits = 4'h0;
        end
        else if (q.cyc + 8'h01 >= bit_cycles)
        begin
            // zero period is taken as one cycle per bit
            next_q.cyc = 8'h00;
            if (q.bits == cce_pkg::BITS_PER_BYTE - 4'h1)
            begin
                next_q.bits = 4'h0;
                next_q.tick = 1'b1;
            end
            else
            begin
                next_q.bits = q.bits + 4'h1;
            end
        end
        else
        begin
            next_q.cyc = q.cyc + 8'h01;
        end
    end

    // state register
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            q <= '0;
        else
            q <= next_q;
    end

    assign byte_tick = q.tick;
endmodule : cce_byte_timer
`default_nettype wire

// ===== cce_executor.sv
// calibration command executor: nibble interface, command decode,
// calibration registers, nonvolatile byte store and analog probe timing
// assumes apb master at pclk; serial framing sits outside this block
`timescale 1ns/10ps
`default_nettype none
module cce_executor #(
    parameter logic [7:0] TEST_DATA = 8'h00 // internal test readback
)
(
    input  wire logic                   pclk,
    input  wire logic                   presetn,
    input  wire logic                   psel,
    input  wire logic                   penable,
    input  wire logic                   pwrite,
    input  wire logic [7:0]             paddr,
    input  wire logic [31:0]            pwdata,
    output logic      [31:0]            prdata,
    output logic                        pready,
    output logic                        pslverr,
    input  wire logic [7:0]             temp_index,
    output cce_pkg::cce_cal_regs_t      cal_regs,
    output cce_pkg::cce_probe_t         probe,
    output cce_pkg::cce_readback_t      readback,
    output logic                        busy
);
    cce_pkg::cce_exec_t q;          // registered state
    cce_pkg::cce_exec_t next_q;     // next state
    logic [7:0]  store_mem [0:767]; // nonvolatile store image
    logic        mem_we;            // store write strobe
    logic [9:0]  mem_addr;          // store write address
    logic [7:0]  mem_wd;            // store write data
    logic [7:0]  mem_rd;            // byte at store address
    logic [9:0]  store_address;     // assembled store address
    logic        store_ok;          // address inside the store
    logic        cal_ok;            // select names a real register
    logic [15:0] cal_pick;          // selected calibration register
    logic [7:0]  rb_byte;           // pointer-selected value
    logic [15:0] span_count;        // byte times for the probe
    logic        byte_tick;         // one pulse per byte time
    logic        access;            // apb access phase
    logic        bus_wr;            // apb write taking effect
    logic        wr_nib;            // accepted nibble write
    logic [3:0]  nib_addr;          // nibble address field
    logic [3:0]  nib_val;           // nibble value field
    logic        is_cmd;            // accepted command write
    logic        mapped;            // address hits a register
    logic [3:0]  page;              // page under wipe

    // address bits 9:8 are shared with the pointer low bits
    assign store_address = {q.readback_pointer[1:0], q.addr_mid,
                            q.cal_register_select};
    assign store_ok = store_address < cce_pkg::STORE_BYTES;
    assign mem_rd   = store_ok ? store_mem[store_address]
                               : cce_pkg::ERASED_BYTE;
    assign cal_ok   = q.cal_register_select < cce_pkg::CAL_COUNT;
    assign cal_pick = cal_ok ? q.cal[q.cal_register_select[2:0]]
                             : 16'h0000;
    assign page     = store_address[9:6];

    // bus decode; nibble writes are refused while a command runs
    assign access   = psel && penable;
    assign bus_wr   = access && pwrite;
    assign nib_addr = pwdata[7:4];
    assign nib_val  = pwdata[3:0];
    assign wr_nib   = bus_wr && paddr == cce_pkg::REG_NIBBLE
                      && q.st == cce_pkg::CCE_IDLE;
    assign is_cmd   = wr_nib && nib_addr == cce_pkg::NA_COMMAND;
    assign mapped   = paddr == cce_pkg::REG_NIBBLE
                      || paddr == cce_pkg::REG_STATUS
                      || paddr == cce_pkg::REG_HOLDING
                      || paddr == cce_pkg::REG_READBACK
                      || paddr == cce_pkg::REG_BAUD
                      || paddr == cce_pkg::REG_ADDRESS;

    // probe span: code 15 is the long acceptance lockout
    always_comb
    begin
        if (q.analog_hold_length == cce_pkg::HOLD_FOREVER)
            span_count = cce_pkg::LONG_SPAN;
        else
            span_count = (16'h0001 << q.analog_hold_length)
                         + 16'h0001;
    end

    // readback pointer decode
    always_comb
    begin
        case (q.readback_pointer)
            cce_pkg::PTR_HOLD_LO:  rb_byte = q.holding_word[7:0];
            cce_pkg::PTR_HOLD_HI:  rb_byte = q.holding_word[15:8];
            cce_pkg::PTR_ADDR_SEL: rb_byte = {q.addr_mid,
                                              q.cal_register_select};
            cce_pkg::PTR_CMD_PTR:  rb_byte = {q.command_nibble,
                                              q.readback_pointer};
            cce_pkg::PTR_ANALOG:   rb_byte = {q.probe.source,
                                              q.analog_hold_length};
            cce_pkg::PTR_ADDR_LO:  rb_byte = store_address[7:0];
            cce_pkg::PTR_DATA:     rb_byte = mem_rd;
            cce_pkg::PTR_TEMP:     rb_byte = temp_index;
            cce_pkg::PTR_BAUD:     rb_byte = q.baud_period_count;
            cce_pkg::PTR_TEST:     rb_byte = TEST_DATA;
            default:               rb_byte = cce_pkg::CHECK_PATTERN;
        endcase
    end

    // main next-state logic
    always_comb
    begin
        next_q   = q;
        mem_we   = 1'b0;
        mem_addr = store_address;
        mem_wd   = q.holding_word[7:0];
        next_q.rb.valid = 1'b0;
        // baud count may change at any time; it only paces probes
        if (bus_wr && paddr == cce_pkg::REG_BAUD)
            next_q.baud_period_count = pwdata[7:0];
        case (q.st)
            cce_pkg::CCE_IDLE:
            begin
                if (wr_nib)
                begin
                    case (nib_addr)
                        4'h0, 4'h1, 4'h2, 4'h3:
                            next_q.holding_word[{nib_addr[1:0], 2'b00} +: 4]
                                = nib_val;
                        cce_pkg::NA_STORE_LO:
                            next_q.cal_register_select = nib_val;
                        cce_pkg::NA_STORE_MID:
                            next_q.addr_mid = nib_val;
                        cce_pkg::NA_POINTER:
                            next_q.readback_pointer = nib_val;
                        cce_pkg::NA_HOLD_LEN:
                            next_q.analog_hold_length = nib_val;
                        cce_pkg::NA_SOURCE:
                            next_q.probe.source = nib_val;
                        cce_pkg::NA_COMMAND:
                        begin
                            // a new command ends any free-running probe
                            next_q.command_nibble = nib_val;
                            next_q.probe.drive = 1'b0;
                            case (nib_val)
                                cce_pkg::LOAD_CAL_COMMAND:
                                begin
                                    // reserved selects are never loaded
                                    if (cal_ok)
                                        next_q.cal[
                                            q.cal_register_select[2:0]]
                                            = q.holding_word;
                                end
                                cce_pkg::STORE_WRITE_COMMAND:
                                begin
                                    mem_we = store_ok;
                                end
                                cce_pkg::STORE_ERASE_COMMAND:
                                begin
                                    next_q.wipe_addr = 10'h000;
                                    next_q.wipe_end  = cce_pkg::STORE_LAST;
                                    next_q.st = cce_pkg::CCE_WIPE;
                                end
                                cce_pkg::READ_CAL_COMMAND:
                                    next_q.holding_word = cal_pick;
                                cce_pkg::STORE_READ_COMMAND:
                                    next_q.holding_word[7:0] = mem_rd;
                                cce_pkg::INTERFACE_READ_COMMAND:
                                begin
                                    next_q.rb.valid = 1'b1;
                                    next_q.rb.data  = rb_byte;
                                end
                                cce_pkg::ANALOG_PROBE_COMMAND:
                                begin
                                    next_q.probe.drive = 1'b1;
                                    next_q.span_left = span_count;
                                    next_q.st = cce_pkg::CCE_PROBE;
                                end
                                cce_pkg::BLOCK_WIPE_COMMAND:
                                begin
                                    // pages past the last one are ignored
                                    if (page < cce_pkg::PAGE_COUNT)
                                    begin
                                        next_q.wipe_addr = {page, 6'h00};
                                        next_q.wipe_end  = {page,
                                                       cce_pkg::PAGE_LAST};
                                        next_q.st = cce_pkg::CCE_WIPE;
                                    end
                                end
                                default: ;
                            endcase
                        end
                        default: ; // reserved nibble addresses
                    endcase
                end
            end
            cce_pkg::CCE_WIPE:
            begin
                // one byte per cycle; slower than one wide clear, far
                // cheaper than a second write port
                mem_we   = 1'b1;
                mem_addr = q.wipe_addr;
                mem_wd   = cce_pkg::ERASED_BYTE;
                if (q.wipe_addr == q.wipe_end)
                    next_q.st = cce_pkg::CCE_IDLE;
                else
                    next_q.wipe_addr = q.wipe_addr + 10'h001;
            end
            cce_pkg::CCE_PROBE:
            begin
                if (byte_tick)
                begin
                    if (q.span_left == 16'h0001)
                    begin
                        next_q.st = cce_pkg::CCE_IDLE;
                        // code 15 keeps driving after the lockout
                        if (q.analog_hold_length != cce_pkg::HOLD_FOREVER)
                            next_q.probe.drive = 1'b0;
                    end
                    else
                    begin
                        next_q.span_left = q.span_left - 16'h0001;
                    end
                end
            end
            default: next_q.st = cce_pkg::CCE_IDLE;
        endcase
    end

    // state register
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            q <= '0;
            q.st <= cce_pkg::CCE_IDLE;
            q.baud_period_count <= cce_pkg::BAUD_RESET;
        end
        else
        begin
            q <= next_q;
        end
    end

    // store array; contents are not cleared by reset, as in a real store
    always_ff @(posedge pclk)
    begin
        if (mem_we)
            store_mem[mem_addr] <= mem_wd;
    end

    // byte-time pacing runs only while probing
    cce_byte_timer u_timer
    (
        .pclk       (pclk),
        .presetn    (presetn),
        .run        (q.st == cce_pkg::CCE_PROBE),
        .bit_cycles (q.baud_period_count),
        .byte_tick  (byte_tick)
    );

    // apb read mux and answer; zero wait states
    always_comb
    begin
        case (paddr)
            cce_pkg::REG_STATUS:   prdata = {29'h0, q.st == cce_pkg::CCE_IDLE,
                                             q.probe.drive, busy};
            cce_pkg::REG_HOLDING:  prdata = {16'h0, q.holding_word};
            cce_pkg::REG_READBACK: prdata = {24'h0, q.rb.data};
            cce_pkg::REG_BAUD:     prdata = {24'h0, q.baud_period_count};
            cce_pkg::REG_ADDRESS:  prdata = {22'h0, store_address};
            default:               prdata = 32'h0;
        endcase
    end

    // errors: unmapped, busy nibble write, write to a read-only word
    assign pready  = 1'b1;
    assign pslverr = access && (!mapped
                     || (pwrite && paddr == cce_pkg::REG_NIBBLE && busy)
                     || (pwrite && paddr != cce_pkg::REG_NIBBLE
                         && paddr != cce_pkg::REG_BAUD));
    assign busy     = q.st != cce_pkg::CCE_IDLE;
    assign cal_regs = q.cal;
    assign probe    = q.probe;
    assign readback = q.rb;

    // helper: cycles spent in the current wipe
    logic [10:0] wipe_len;
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            wipe_len <= 11'h000;
        else if (q.st == cce_pkg::CCE_WIPE)
            wipe_len <= wipe_len + 11'h001;
        else
            wipe_len <= 11'h000;
    end

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    sequence s_cmd(logic [3:0] code);
        is_cmd && nib_val == code;
    endsequence

    a_cal_load: assert property (s_cmd(4'h0) ##0 cal_ok
        |=> q.cal[$past(q.cal_register_select[2:0])] == $past(q.holding_word))
        else $error("calibration load lost");
    a_store_write: assert property (s_cmd(4'h1) ##0 store_ok
        |-> mem_we && mem_wd == q.holding_word[7:0])
        else $error("store write missing");
    a_wipe_data: assert property (q.st == cce_pkg::CCE_WIPE
        |-> mem_we && mem_wd == 8'hFF)
        else $error("wipe writes wrong value");
    a_wipe_span: assert property (q.st == cce_pkg::CCE_WIPE
        && q.wipe_addr == q.wipe_end && q.command_nibble == 4'h2
        |-> wipe_len == 11'd767)
        else $error("bulk erase length wrong");
    a_page_span: assert property (q.st == cce_pkg::CCE_WIPE
        && q.wipe_addr == q.wipe_end && q.command_nibble == 4'h7
        |-> wipe_len == 11'd63 && q.wipe_end[5:0] == 6'h3F)
        else $error("page erase length wrong");
    a_cal_read: assert property (s_cmd(4'h3)
        |=> q.holding_word == $past(cal_pick))
        else $error("calibration read wrong");
    a_store_read: assert property (s_cmd(4'h4)
        |=> q.holding_word[7:0] == $past(mem_rd)
            && $stable(q.holding_word[15:8]))
        else $error("store read wrong");
    a_check_pattern: assert property (s_cmd(4'h5)
        ##0 q.readback_pointer >= 4'hA
        |=> readback.valid && readback.data == 8'hCA)
        else $error("check pattern wrong");
    a_span_load: assert property (s_cmd(4'h6)
        ##0 q.analog_hold_length == 4'h0
        |=> q.span_left == 16'd2 && probe.drive)
        else $error("short span wrong");
    a_long_span: assert property (s_cmd(4'h6)
        ##0 q.analog_hold_length == 4'hF
        |=> q.span_left == 16'd32769 && busy)
        else $error("long span wrong");
    a_drive_end: assert property (q.st == cce_pkg::CCE_PROBE
        && byte_tick && q.span_left == 16'd1
        |=> !busy && probe.drive == ($past(q.analog_hold_length) == 4'hF))
        else $error("probe end wrong");
    a_reserved_cmd: assert property (is_cmd && nib_val[3]
        |-> !mem_we ##1 $stable(q.cal) && $stable(q.holding_word) && !busy)
        else $error("reserved command acted");
    a_nibble_fill: assert property (wr_nib && nib_addr == 4'h2
        |=> q.holding_word[11:8] == $past(nib_val))
        else $error("holding nibble lost");
endmodule : cce_executor
`default_nettype wire

// ===== cce_prog_model.sv
// far-side model: the sensor front end seen by the executor
// assumes a steady temperature index while a test runs
`timescale 1ns/10ps
`default_nettype none
module cce_prog_model #(
    parameter logic [7:0] TEMP = 8'h41 // steady room reading
)
(
    output logic [7:0] temp_index
);
    // level held constant, sampled when read back
    assign temp_index = TEMP;
endmodule : cce_prog_model
`default_nettype wire

// ===== cce_executor_test.sv
// self-checking bench for the calibration command executor
// assumes cce_pkg, the executor and the front-end model compiled first
`timescale 1ns/10ps
`default_nettype none
module cce_executor_test;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, busy;
    logic [7:0]  paddr, temp_index;
    logic [31:0] pwdata, prdata, rd;
    logic        se; // error flag of the last transfer
    cce_pkg::cce_cal_regs_t cal_regs;
    cce_pkg::cce_probe_t    probe;
    cce_pkg::cce_readback_t readback;
    int          err_total, compares, n, s;
    cce_prog_model fe (.temp_index(temp_index));
    cce_executor DUT (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .temp_index(temp_index), .cal_regs(cal_regs), .probe(probe),
        .readback(readback), .busy(busy));
    // free-running 250 MHz clock
    initial
    begin
        pclk = 1'b0;
        forever #2 pclk = ~pclk;
    end
    // one apb transfer; held until pready is seen at an edge
    task automatic apb(input logic [7:0] a, input logic w,
                       input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        paddr <= a;
        pwrite <= w;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk iff pready === 1'b1);
        rd = prdata;
        se = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    // one interface nibble write
    task automatic nib(input logic [3:0] a, input logic [3:0] v);
        apb(cce_pkg::REG_NIBBLE, 1'b1, {24'h000000, a, v});
    endtask : nib
    // let a started command run out
    task automatic idle();
        repeat (2) @(posedge pclk);
        @(posedge pclk iff busy === 1'b0);
    endtask : idle
    task automatic cmp(input string w, input logic [31:0] e,
                       input logic [31:0] g);
        compares++;
        if (g !== e)
        begin
            err_total++;
            $display("wrong value %s expected %h seen %h", w, e, g);
        end
    endtask : cmp
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", compares, err_total);
        if (err_total == 0 && compares > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : report_and_stop
    // watchdog well beyond the expected run
    initial
    begin
        repeat (40000) @(posedge pclk);
        err_total++;
        report_and_stop();
    end
    // main sequence
    initial
    begin
        {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        apb(cce_pkg::REG_BAUD, 1'b0, 32'h0);
        cmp("baud", {24'h0, cce_pkg::BAUD_RESET}, rd);
        for (int i = 0; i < 4; i++) nib(i[3:0], 4'hC - i[3:0]);
        apb(cce_pkg::REG_HOLDING, 1'b0, 32'h0);
        cmp("holding", 32'h9ABC, rd);
        for (int i = 0; i < 5; i++)
        begin
            nib(4'h6, i[3:0]);
            nib(4'h9, 4'h0);
            @(negedge pclk);
            cmp("cal", 32'h9ABC, {16'h0, cal_regs[i]});
        end
        nib(4'h0, 4'h0);
        nib(4'h9, 4'h3);
        apb(cce_pkg::REG_HOLDING, 1'b0, 32'h0);
        cmp("cal read", 32'h9ABC, rd);
        $display("calibration test done");
        nib(4'h6, 4'h3);
        nib(4'h7, 4'h2);
        nib(4'h8, 4'h0);
        for (int k = 0; k < 2; k++)
        begin
            nib(4'h0, 4'hC);
            nib(4'h1, 4'hB);
            nib(4'h9, 4'h1);
            nib(4'h0, 4'h0);
            nib(4'h9, 4'h4);
            apb(cce_pkg::REG_HOLDING, 1'b0, 32'h0);
            cmp("store", 32'h9ABC, rd);
            nib(4'h9, (k == 0) ? 4'h7 : 4'h2);
            nib(4'h2, 4'h5);
            cmp("refused", 1, {31'h0, se});
            idle();
            nib(4'h9, 4'h4);
            apb(cce_pkg::REG_HOLDING, 1'b0, 32'h0);
            cmp("erased", 32'h9AFF, rd);
        end
        nib(4'h9, 4'h8);
        apb(cce_pkg::REG_HOLDING, 1'b0, 32'h0);
        cmp("reserved", 32'h9AFF, rd);
        $display("store test done");
        for (int p = 0; p < 16; p++)
        begin
            nib(4'h8, p[3:0]);
            nib(4'h9, 4'h5);
            @(negedge pclk);
            cmp("valid", 1, {31'h0, readback.valid});
            idle();
            case (p)
                0, 6:    s = 8'hFF;
                1:       s = 8'h9A;
                2, 5:    s = 8'h23;
                3:       s = 8'h53;
                4, 9:    s = 8'h00;
                7:       s = 8'h41;
                8:       s = 8'h04;
                default: s = 8'hCA;
            endcase
            cmp("readback", s, {24'h0, readback.data});
        end
        $display("readback test done");
        apb(cce_pkg::REG_BAUD, 1'b1, 32'h1);
        for (int c = 0; c < 3; c++)
        begin
            nib(4'hA, c[3:0]);
            nib(4'hB, 4'h3);
            nib(4'h9, 4'h6);
            n = 0;
            s = ((1 << c) + 1) * 8;
            do
            begin
                @(negedge pclk);
                n++;
            end
            while (busy === 1'b1 && n < 70000);
            cmp("span", 1, {31'h0, n >= s && n <= s + 3});
            cmp("source", 3, {28'h0, probe.source});
            cmp("drive", 0, {31'h0, probe.drive});
        end
        $display("probe test done");
        nib(4'hA, 4'hF);
        nib(4'h9, 4'h6);
        repeat (100) @(posedge pclk);
        cmp("lockout", 3, {30'h0, busy, probe.drive});
        presetn <= 1'b0;
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        apb(cce_pkg::REG_BAUD, 1'b0, 32'h0);
        cmp("baud again", {24'h0, cce_pkg::BAUD_RESET}, rd);
        $display("reset test done");
        report_and_stop();
    end
endmodule : cce_executor_test
`default_nettype wire
